// ### logic/uxr_ext_regs.sv
`timescale 1ns/1ps
module uxr_ext_regs (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic SOFT_RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic [7:0] FIFO_CONTROL_REG,
   input wire logic [7:0] INTERRUPT_ENABLE_REG,
   input wire logic ENHANCED_MODE,
   input wire logic POWER_STATE_D2,
   input wire logic GOOD_DATA,
   input wire logic RX_PUSH,
   input wire logic [8:0] RX_CHAR,
   input wire logic RX_DMA_REQ,
   input wire logic TX_DMA_REQ,
   input wire logic CTS_N,
   input wire logic DSR_N,
   input wire logic RI_N,
   input wire logic DCD_N,
   input wire logic SERIAL_DATA_INPUT,
   output logic NINE_BIT_MODE,
   output logic LSR_BIT2,
   output logic ADDR_CHAR_INT,
   output logic SPECIAL_CHAR_INT,
   output logic RING_INT,
   output logic [3:0] MODEM_DELTA,
   output logic PME,
   output logic WAKE,
   output logic RECEIVE_DMA_REQUEST_N,
   output logic TRANSMIT_DMA_REQUEST_N,
   output logic [7:0] CLOCK_ALTERATION
);
   //==========================================================================
   // state
   typedef struct packed {
      logic [7:0] nbc;
      logic [7:0] mem;
      logic [7:0] clock_alteration;
      logic [3:0][7:0] spc;
      logic [1:0] force_bits;
      logic [7:0] rdata;
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic [4:0] prev;
      logic lsr2;
      logic addr_int;
      logic spc_int;
      logic ring_int;
      logic [3:0] delta;
      logic pme;
      logic wake;
      logic rx_req_n;
      logic tx_req_n;
   } uxr_state_s;

   uxr_state_s r;
   uxr_state_s next_r;

   // line order in the sync vector: cts, dsr, ri, dcd, serial input
   logic [4:0] pins;
   logic [4:0] changed;
   logic ri_trail;
   logic [3:0] allowed;
   logic [3:0] hit;
   logic [8:0] pattern;
   logic sin_evt;

   assign pins = {SERIAL_DATA_INPUT, DCD_N, RI_N, DSR_N, CTS_N};

   //==========================================================================
   // next state
   always_comb begin
      next_r = r;
      pattern = 9'h000;
      hit = 4'h0;
      // first stage feeds only the second stage
      next_r.sync1 = pins;
      next_r.sync2 = r.sync1;
      next_r.prev = r.sync2;
      changed = r.sync2 ^ r.prev;
      // ring indicator active low: trailing edge is low to high
      ri_trail = r.sync2[2] & ~r.prev[2];
      allowed[0] = changed[0] & ~r.mem[uxr_pkg::MEM_CTS]; // RL7
      allowed[1] = changed[1] & ~r.mem[uxr_pkg::MEM_DSR]; // RL8
      allowed[2] = ri_trail & ~r.mem[uxr_pkg::MEM_RI]; // RL10
      allowed[3] = changed[3] & ~r.mem[uxr_pkg::MEM_DCD]; // RL11
      sin_evt = changed[4] & ~r.mem[uxr_pkg::MEM_SIN]; // RL13
      next_r.delta = allowed;
      next_r.ring_int = allowed[2] & INTERRUPT_ENABLE_REG[uxr_pkg::IER_MODEM]; // RL9
      // power event only in D2; masked lines never reach it
      next_r.pme = POWER_STATE_D2 & ((|allowed) | sin_evt); // RL9
      next_r.wake = |allowed; // RL9

      // receive side
      for (int i = 0; i < 4; i++) begin
         pattern = {r.nbc[uxr_pkg::NBC_SPC_LSB + i], r.spc[i]}; // RL4
         hit[i] = (RX_CHAR == pattern);
      end
      next_r.addr_int = RX_PUSH & r.nbc[uxr_pkg::NBC_ENABLE] &
                        r.nbc[uxr_pkg::NBC_ADDR_INT] & RX_CHAR[8]; // RL2
      next_r.spc_int = RX_PUSH & r.nbc[uxr_pkg::NBC_ENABLE] & ENHANCED_MODE &
                       INTERRUPT_ENABLE_REG[uxr_pkg::IER_SPECIAL] & (|hit); // RL3 RL23
      if (RX_PUSH) begin
         // parity is off in nine-bit framing, so the slot carries the ninth bit
         next_r.lsr2 = r.nbc[uxr_pkg::NBC_ENABLE] & RX_CHAR[8]; // RL22
      end

      // dma request lines, forced high when the force bit is set
      next_r.rx_req_n = ~(RX_DMA_REQ & ~r.force_bits[0]); // RL18
      next_r.tx_req_n = ~(TX_DMA_REQ & ~r.force_bits[1]); // RL19

      // register writes; unmapped and read-only indexes are ignored
      if (WR) begin
         case (ADDR)
            uxr_pkg::IDX_NINE_BIT_CONTROL: begin
               next_r.nbc = WDATA & uxr_pkg::NBC_WMASK; // RL5 RL24
            end
            uxr_pkg::IDX_MODEM_EVENT_MASK: begin
               // bit 4 dropped even if software breaks the zero convention
               next_r.mem = WDATA & uxr_pkg::MEM_WMASK; // RL12 RL24
            end
            uxr_pkg::IDX_DMA_READY_STATUS_FORCE: begin
               next_r.force_bits = {WDATA[uxr_pkg::DMS_TX_FORCE],
                                    WDATA[uxr_pkg::DMS_RX_FORCE]}; // RL24
            end
            uxr_pkg::IDX_CLOCK_ALTERATION: begin
               next_r.clock_alteration = WDATA;
            end
            uxr_pkg::IDX_SPECIAL_CHAR_ONE: begin
               next_r.spc[0] = WDATA;
            end
            uxr_pkg::IDX_SPECIAL_CHAR_TWO: begin
               next_r.spc[1] = WDATA;
            end
            uxr_pkg::IDX_SPECIAL_CHAR_THREE: begin
               next_r.spc[2] = WDATA;
            end
            uxr_pkg::IDX_SPECIAL_CHAR_FOUR: begin
               next_r.spc[3] = WDATA;
            end
            default: begin
            end
         endcase
      end

      // read data stands for exactly one cycle after the strobe
      next_r.rdata = 8'h00;
      if (RD) begin
         case (ADDR)
            uxr_pkg::IDX_NINE_BIT_CONTROL: next_r.rdata = r.nbc; // RL5
            uxr_pkg::IDX_MODEM_EVENT_MASK: next_r.rdata = r.mem;
            uxr_pkg::IDX_FIFO_CONTROL_READBACK: next_r.rdata = FIFO_CONTROL_REG; // RL14
            uxr_pkg::IDX_GOOD_DATA_FLAG: next_r.rdata = {7'h00, GOOD_DATA}; // RL15
            uxr_pkg::IDX_DMA_READY_STATUS_FORCE: begin
               next_r.rdata = {r.force_bits, 4'h0, ~r.tx_req_n, ~r.rx_req_n}; // RL16 RL17
            end
            uxr_pkg::IDX_PORT_INDEX: next_r.rdata = uxr_pkg::PORT_NUMBER; // RL20
            uxr_pkg::IDX_CLOCK_ALTERATION: next_r.rdata = r.clock_alteration;
            uxr_pkg::IDX_SPECIAL_CHAR_ONE: next_r.rdata = r.spc[0];
            uxr_pkg::IDX_SPECIAL_CHAR_TWO: next_r.rdata = r.spc[1];
            uxr_pkg::IDX_SPECIAL_CHAR_THREE: next_r.rdata = r.spc[2];
            uxr_pkg::IDX_SPECIAL_CHAR_FOUR: next_r.rdata = r.spc[3];
            default: next_r.rdata = 8'h00;
         endcase
      end

      // channel reset: clock mode and event mask survive so software can
      // pick a clock first and then reset the channel cleanly
      if (SOFT_RST) begin
         next_r.nbc = uxr_pkg::NBC_RESET;
         next_r.force_bits = 2'b00;
         next_r.lsr2 = 1'b0;
         next_r.addr_int = 1'b0;
         next_r.spc_int = 1'b0;
         for (int i = 0; i < 4; i++) begin
            next_r.spc[i] = uxr_pkg::SPC_RESET;
         end
      end // RL21
   end

   //==========================================================================
   // registers
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         r <= '0;
         r.nbc <= uxr_pkg::NBC_RESET;
         r.mem <= uxr_pkg::MEM_RESET; // RL6
         r.clock_alteration <= uxr_pkg::CKA_RESET; // RL21
         r.sync1 <= 5'h1f;
         r.sync2 <= 5'h1f;
         r.prev <= 5'h1f;
         r.rx_req_n <= 1'b1;
         r.tx_req_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   //==========================================================================
   // outputs
   assign RDATA = r.rdata;
   assign NINE_BIT_MODE = r.nbc[uxr_pkg::NBC_ENABLE]; // RL1
   assign LSR_BIT2 = r.lsr2;
   assign ADDR_CHAR_INT = r.addr_int;
   assign SPECIAL_CHAR_INT = r.spc_int;
   assign RING_INT = r.ring_int;
   assign MODEM_DELTA = r.delta;
   assign PME = r.pme;
   assign WAKE = r.wake;
   assign RECEIVE_DMA_REQUEST_N = r.rx_req_n;
   assign TRANSMIT_DMA_REQUEST_N = r.tx_req_n;
   assign CLOCK_ALTERATION = r.clock_alteration;
endmodule : uxr_ext_regs

// ### logic/uxr_pkg.sv
//==========================================================================
// Overview of operation
// RL1 - nine_bit_control bit 0 selects nine-bit framing, otherwise normal framing
// RL2 - nine_bit_control bit 1 raises level 1 interrupt on received ninth bit set
// RL3 - ier bit 5 enables four-character detection only in nine-bit plus enhanced mode
// RL4 - match against four nine-bit patterns: special chars plus nine_bit_control bits 2-5
// RL5 - nine_bit_control bits 7 and 6 always read zero
// RL6 - hardware reset clears modem_event_mask, enabling every modem event
// RL7 - mask bit 0 blocks cts change from interrupt, power event and wake
// RL8 - mask bit 1 blocks dsr change from interrupt, power event and wake
// RL9 - unmasked ring trailing edge: level 4 interrupt with ier 3, power event in D2, wake
// RL10 - mask bit 2 blocks ring trailing edge from interrupt, power event and wake
// RL11 - mask bit 3 blocks carrier-detect change from interrupt, power event and wake
// RL12 - software writes zero to modem_event_mask bit 4
// RL13 - mask bit 5 stops serial input change asserting power event in D2
// RL14 - index 0x0f reads back the write-only fifo control register
// RL15 - good_data_flag bit 0 is good-data status, bits 7 to 1 zero
// RL16 - dma status bit 0 reads one while receive request line is low
// RL17 - dma status bit 1 reads one while transmit request line is low
// RL18 - dma force bit 6 holds receive request deasserted
// RL19 - dma force bit 7 holds transmit request deasserted
// RL20 - port_index at 0x12 reads channel number zero
// RL21 - clock_alteration clears on hardware reset, survives channel software reset
// RL22 - in nine-bit framing the ninth bit goes into line status bit 2
// RL23 - special character match raises level 5 interrupt as character enters fifo
// RL24 - writes to read-only or reserved bits ignored, reserved bits read zero
//==========================================================================
package uxr_pkg;
   //==========================================================================
   // register indexes
   localparam logic [7:0] IDX_NINE_BIT_CONTROL = 8'h0d;
   localparam logic [7:0] IDX_MODEM_EVENT_MASK = 8'h0e;
   localparam logic [7:0] IDX_FIFO_CONTROL_READBACK = 8'h0f;
   localparam logic [7:0] IDX_GOOD_DATA_FLAG = 8'h10;
   localparam logic [7:0] IDX_DMA_READY_STATUS_FORCE = 8'h11;
   localparam logic [7:0] IDX_PORT_INDEX = 8'h12;
   localparam logic [7:0] IDX_CLOCK_ALTERATION = 8'h13;
   localparam logic [7:0] IDX_SPECIAL_CHAR_ONE = 8'h20;
   localparam logic [7:0] IDX_SPECIAL_CHAR_TWO = 8'h21;
   localparam logic [7:0] IDX_SPECIAL_CHAR_THREE = 8'h22;
   localparam logic [7:0] IDX_SPECIAL_CHAR_FOUR = 8'h23;
   //==========================================================================
   // field positions
   localparam int NBC_ENABLE = 0;
   localparam int NBC_ADDR_INT = 1;
   localparam int NBC_SPC_LSB = 2;
   localparam int MEM_CTS = 0;
   localparam int MEM_DSR = 1;
   localparam int MEM_RI = 2;
   localparam int MEM_DCD = 3;
   localparam int MEM_SIN = 5;
   localparam int IER_MODEM = 3;
   localparam int IER_SPECIAL = 5;
   localparam int DMS_RX_STAT = 0;
   localparam int DMS_TX_STAT = 1;
   localparam int DMS_RX_FORCE = 6;
   localparam int DMS_TX_FORCE = 7;
   //==========================================================================
   // writable bit masks and reset values
   localparam logic [7:0] NBC_WMASK = 8'h3f;
   localparam logic [7:0] MEM_WMASK = 8'h2f;
   localparam logic [7:0] NBC_RESET = 8'h00;
   localparam logic [7:0] MEM_RESET = 8'h00;
   localparam logic [7:0] CKA_RESET = 8'h00;
   localparam logic [7:0] SPC_RESET = 8'h00;
   localparam logic [7:0] PORT_NUMBER = 8'h00;
endpackage : uxr_pkg

// ### sim/testbench.sv
`timescale 1ns/1ps
//==========================================================================
// bench top
module testbench;
   logic CLOCK, RST_N = '0, SOFT_RST = '0, WR = '0, RD = '0, ENHANCED_MODE = '0;
   logic POWER_STATE_D2 = '0, GOOD_DATA = '0, RX_PUSH = '0, RX_DMA_REQ = '0, TX_DMA_REQ = '0;
   logic [7:0] ADDR = '0, WDATA = '0, FIFO_CONTROL_REG = '0, INTERRUPT_ENABLE_REG = '0;
   logic [8:0] RX_CHAR = '0;
   logic [4:0] flip = '0;
   wire logic CTS_N, DSR_N, RI_N, DCD_N, SERIAL_DATA_INPUT;
   logic [7:0] RDATA, CLOCK_ALTERATION;
   logic [3:0] MODEM_DELTA;
   logic NINE_BIT_MODE, LSR_BIT2, ADDR_CHAR_INT, SPECIAL_CHAR_INT, RING_INT, PME, WAKE;
   logic RECEIVE_DMA_REQUEST_N, TRANSMIT_DMA_REQUEST_N, arm = '0;
   logic [6:0] acc;
   logic [31:0] seed = 32'h3c;
   int n_errors = 0, compares = 0;
   uxr_ext_regs uut (.*);
   uxr_modem modem (.clk(CLOCK), .flip(flip),
      .pins({SERIAL_DATA_INPUT, DCD_N, RI_N, DSR_N, CTS_N}));
   initial begin
      CLOCK = 1'h0;
      forever #50 CLOCK = ~CLOCK;
   end
   // collector clears itself while disarmed, so no second writer is needed
   always @(posedge CLOCK)
      acc <= arm ? acc | {PME, WAKE, RING_INT, MODEM_DELTA} : 7'h0;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic [7:0] evx(input int p, input logic m, input logic q);
      return m ? 8'h0 : {1'h0, ~q, 1'(p < 4), 1'(p == 2) & ~q, (p < 4) ? 4'h1 << p : 4'h0};
   endfunction : evx
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
         n_errors++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      WR <= 1'h1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLOCK);
      WR <= 1'h0;
   endtask : wr
   task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] exp);
      @(posedge CLOCK);
      RD <= 1'h1;
      ADDR <= a;
      @(posedge CLOCK);
      RD <= 1'h0;
      #1 chk(nm, RDATA, exp);
   endtask : rc
   task automatic ev(input int p, input logic m, input logic q);
      POWER_STATE_D2 <= ~q;
      INTERRUPT_ENABLE_REG <= q ? 8'h00 : 8'h08;
      wr(uxr_pkg::IDX_MODEM_EVENT_MASK, m ? ((p < 4) ? 8'h1 << p : 8'h20) : 8'h0);
      #1 arm = 1'h1;
      repeat (2) begin
         @(posedge CLOCK);
         flip <= 5'h1 << p;
         @(posedge CLOCK);
         flip <= 5'h0;
         repeat (6) @(posedge CLOCK);
      end
      #1 arm = 1'h0;
      chk("events", {1'h0, acc}, evx(p, m, q));
   endtask : ev
   task automatic conclude();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude
   initial begin
      logic [31:0] v;
      logic [8:0] c;
      repeat (10) @(posedge CLOCK);
      RST_N <= 1'h1;
      rc("mask", uxr_pkg::IDX_MODEM_EVENT_MASK, uxr_pkg::MEM_RESET);
      rc("cka", uxr_pkg::IDX_CLOCK_ALTERATION, 8'h00);
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         v = (i == 0) ? 32'hffffffff : seed;
         FIFO_CONTROL_REG <= v[7:0];
         GOOD_DATA <= v[8];
         wr(uxr_pkg::IDX_NINE_BIT_CONTROL, v[15:8]);
         rc("nbc", uxr_pkg::IDX_NINE_BIT_CONTROL, v[15:8] & uxr_pkg::NBC_WMASK);
         wr(uxr_pkg::IDX_MODEM_EVENT_MASK, v[23:16] & 8'hef);
         rc("mask", uxr_pkg::IDX_MODEM_EVENT_MASK, v[23:16] & uxr_pkg::MEM_WMASK);
         wr(uxr_pkg::IDX_FIFO_CONTROL_READBACK, v[31:24]);
         rc("rfc", uxr_pkg::IDX_FIFO_CONTROL_READBACK, v[7:0]);
         rc("gds", uxr_pkg::IDX_GOOD_DATA_FLAG, {7'h0, v[8]});
         wr(uxr_pkg::IDX_PORT_INDEX, v[31:24]);
         rc("pix", uxr_pkg::IDX_PORT_INDEX, uxr_pkg::PORT_NUMBER);
         rc("unmapped", 8'h7f, 8'h00);
      end
      wr(uxr_pkg::IDX_CLOCK_ALTERATION, 8'h5a);
      SOFT_RST <= 1'h1;
      @(posedge CLOCK);
      SOFT_RST <= 1'h0;
      rc("cka", uxr_pkg::IDX_CLOCK_ALTERATION, 8'h5a);
      chk("cka pin", CLOCK_ALTERATION, 8'h5a);
      // hardware reset in mid-run must clear what the channel reset kept
      RST_N <= 1'h0;
      repeat (3) @(posedge CLOCK);
      RST_N <= 1'h1;
      rc("mask rst", uxr_pkg::IDX_MODEM_EVENT_MASK, uxr_pkg::MEM_RESET);
      rc("cka rst", uxr_pkg::IDX_CLOCK_ALTERATION, uxr_pkg::CKA_RESET);
      $display("test registers done");
      RX_DMA_REQ <= 1'h1;
      TX_DMA_REQ <= 1'h1;
      for (int f = 0; f < 4; f++) begin
         wr(uxr_pkg::IDX_DMA_READY_STATUS_FORCE, {2'(f), 6'h3f});
         rc("dms", uxr_pkg::IDX_DMA_READY_STATUS_FORCE, {2'(f), 4'h0, ~2'(f)});
         chk("rx req", RECEIVE_DMA_REQUEST_N, 8'(f % 2));
         chk("tx req", TRANSMIT_DMA_REQUEST_N, 8'(f / 2));
      end
      RX_DMA_REQ <= 1'h0;
      TX_DMA_REQ <= 1'h0;
      wr(uxr_pkg::IDX_DMA_READY_STATUS_FORCE, 8'h00);
      rc("dms idle", uxr_pkg::IDX_DMA_READY_STATUS_FORCE, 8'h00);
      chk("rx idle", RECEIVE_DMA_REQUEST_N, 8'h01);
      chk("tx idle", TRANSMIT_DMA_REQUEST_N, 8'h01);
      $display("test dma done");
      INTERRUPT_ENABLE_REG <= 8'h20;
      ENHANCED_MODE <= 1'h1;
      for (int k = 0; k < 4; k++)
         wr(uxr_pkg::IDX_SPECIAL_CHAR_ONE + 8'(k), 8'h41 + 8'(k));
      wr(uxr_pkg::IDX_NINE_BIT_CONTROL, 8'h17);
      #1 chk("nine", NINE_BIT_MODE, 8'h01);
      for (int k = 0; k < 8; k++) begin
         if (k == 5) ENHANCED_MODE <= 1'h0;
         if (k > 5) wr(uxr_pkg::IDX_NINE_BIT_CONTROL, (k == 6) ? 8'h15 : 8'h00);
         c = {(k == 4) ? 1'h0 : ~1'(k) | 1'(k > 5), 8'h41 + 8'(k % 4)};
         @(posedge CLOCK);
         RX_PUSH <= 1'h1;
         RX_CHAR <= c;
         @(posedge CLOCK);
         RX_PUSH <= 1'h0;
         #1 chk("spc", SPECIAL_CHAR_INT, 8'(k < 4));
         chk("adr", ADDR_CHAR_INT, 8'(c[8] && k < 6));
         chk("lsr2", LSR_BIT2, 8'(c[8] && k < 7));
      end
      chk("normal", NINE_BIT_MODE, 8'h00);
      $display("test nine bit done");
      for (int p = 0; p < 5; p++)
         for (int m = 0; m < 3; m++)
            ev(p, m == 1, m == 2);
      $display("test modem done");
      conclude();
   end
   initial begin
      // ten thousand cycles, roughly twenty times the expected run
      #(10000 * 100);
      n_errors++;
      conclude();
   end
endmodule : testbench
bind uxr_ext_regs uxr_props props_i (.*);

// ### sim/uxr_modem.sv
`timescale 1ns/1ps
//==========================================================================
// remote modem: lines idle high and move only when asked
module uxr_modem (
   input wire logic clk,
   input wire logic [4:0] flip,
   output logic [4:0] pins
);
   // one driver only: the lines start idle and only the clocked flip moves them
   logic [4:0] line = 5'h1f;
   assign pins = line;
   always @(posedge clk) line <= line ^ flip;
endmodule : uxr_modem

// ### sim/uxr_props.sv
`timescale 1ns/1ps
//==========================================================================
// port checker
module uxr_props (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic SOFT_RST,
   input wire logic [7:0] ADDR,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic [7:0] FIFO_CONTROL_REG,
   input wire logic [7:0] INTERRUPT_ENABLE_REG,
   input wire logic ENHANCED_MODE,
   input wire logic POWER_STATE_D2,
   input wire logic RX_PUSH,
   input wire logic [8:0] RX_CHAR,
   input wire logic NINE_BIT_MODE,
   input wire logic LSR_BIT2,
   input wire logic ADDR_CHAR_INT,
   input wire logic SPECIAL_CHAR_INT,
   input wire logic RING_INT,
   input wire logic PME,
   input wire logic [7:0] CLOCK_ALTERATION
);
   // outputs are registered, so causes are looked up one edge back
   wire logic adr_go = RX_PUSH && RX_CHAR[8] && NINE_BIT_MODE;
   wire logic spc_go = RX_PUSH && ENHANCED_MODE && INTERRUPT_ENABLE_REG[5] && NINE_BIT_MODE;
   wire logic ca_wr = WR && ADDR == uxr_pkg::IDX_CLOCK_ALTERATION;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   sequence rd_at(logic [7:0] a);
      $past(RD) && $past(ADDR) == a;
   endsequence
   port_index_a: assert property (
      rd_at(uxr_pkg::IDX_PORT_INDEX) |-> RDATA == uxr_pkg::PORT_NUMBER)
      else $error("port index");
   fifo_readback_a: assert property (
      rd_at(uxr_pkg::IDX_FIFO_CONTROL_READBACK) |-> RDATA == $past(FIFO_CONTROL_REG))
      else $error("fifo readback");
   ninth_bit_a: assert property (
      RX_PUSH && NINE_BIT_MODE && !SOFT_RST |=> LSR_BIT2 == $past(RX_CHAR[8]))
      else $error("ninth bit");
   addr_int_a: assert property (
      ADDR_CHAR_INT |-> $past(adr_go)) else $error("address interrupt");
   special_int_a: assert property (
      SPECIAL_CHAR_INT |-> $past(spc_go)) else $error("special interrupt");
   ring_int_a: assert property (
      RING_INT |-> $past(INTERRUPT_ENABLE_REG[3])) else $error("ring interrupt");
   pme_d2_a: assert property (
      PME |-> $past(POWER_STATE_D2)) else $error("power event");
   clk_alt_keep_a: assert property (
      !ca_wr && !$past(ca_wr) |=> $stable(CLOCK_ALTERATION)) else $error("clock alteration");
   cover property (SPECIAL_CHAR_INT);
   cover property (RING_INT);
   cover property (PME);
endmodule : uxr_props
